// ==== core/vtm_monitor.sv ====
// vtm_monitor: configuration, limit compare and alarm logic of the voltage and temperature monitor
// assumes an apb4 master on clk_i and a front end that delivers one measurement per valid cycle
`timescale 1ns/1ps
module vtm_monitor
	import vtm_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [VTM_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]           pwdata_i,
	input  wire logic [3:0]            pstrb_i,
	output logic                       pready_o,
	output logic [31:0]                prdata_o,
	output logic                       pslverr_o,
	input  wire vtm_meas_t             meas_i,
	output vtm_cfg_t                   cfg_o,
	output logic                       alarm_o
);

	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic [VTM_REG_W-1:0]  gain_q;
	logic [VTM_REG_W-1:0]  ctrl_a_q;
	logic [VTM_REG_W-1:0]  ctrl_b_q;
	logic [VTM_REG_W-1:0]  lim_p0_q;
	logic [VTM_REG_W-1:0]  lim_p1_q;
	logic [VTM_REG_W-1:0]  lim_t_q;
	logic [VTM_REG_W-1:0]  alm_en_q;
	logic [31:0]           prdata_q;
	logic                  pslverr_q;
	vtm_cfg_t              cfg_q;
	logic                  alarm_q;

	logic [5:0]            idx;
	logic                  addr_ok;
	logic                  setup;
	logic                  wr_en;
	logic [VTM_FLAG_N-1:0] flags;
	logic [VTM_FLAG_N-1:0] clr;
	logic [VTM_MEAS_W-1:0] p0_peak;
	logic [VTM_MEAS_W-1:0] p0_floor;
	logic [VTM_MEAS_W-1:0] p1_peak;
	logic [VTM_MEAS_W-1:0] p1_floor;
	logic [VTM_REG_W-1:0]  rd_mux;
	logic                  map_hit;
	logic                  running;
	logic                  samp_p0;
	logic                  samp_p1;
	logic                  samp_t;
	logic [7:0]            gain_calc;
	logic [VTM_GAIN_MSB:0] voltage_gain_divisor;
	logic [VTM_LIM_W-1:0]  pin0_upper_limit;
	logic [VTM_LIM_W-1:0]  pin0_lower_limit;
	logic [VTM_LIM_W-1:0]  pin1_upper_limit;
	logic [VTM_LIM_W-1:0]  pin1_lower_limit;
	logic [VTM_LIM_W-1:0]  temp_upper_limit;
	logic [VTM_LIM_W-1:0]  temp_lower_limit;
	logic [VTM_LIM_W-1:0]  meas_level;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode: read data is latched in the setup cycle, so access always finishes at once

	assign idx      = paddr_i[VTM_ADDR_W-1:2];
	assign addr_ok  = (paddr_i[1:0] == 2'h0);
	assign setup    = psel_i && !penable_i;
	assign wr_en    = psel_i && penable_i && pwrite_i && pstrb_i[0] && map_hit && addr_ok;
	assign pready_o = 1'b1;
	assign prdata_o = prdata_q;
	assign pslverr_o = pslverr_q;

	always_comb begin
		rd_mux  = 8'h00;
		map_hit = 1'b1;
		case (idx)
			VTM_IDX_GAIN:    rd_mux = gain_q;
			VTM_IDX_CTRL_A:  rd_mux = ctrl_a_q;
			VTM_IDX_CTRL_B:  rd_mux = ctrl_b_q;
			VTM_IDX_LIM_P0:  rd_mux = lim_p0_q;
			VTM_IDX_LIM_P1:  rd_mux = lim_p1_q;
			VTM_IDX_LIM_T:   rd_mux = lim_t_q;
			VTM_IDX_ALM_EN:  rd_mux = alm_en_q;
			VTM_IDX_STATUS:  rd_mux = {2'h0, flags};
			VTM_IDX_P0_PEAK: rd_mux = p0_peak;
			VTM_IDX_P0_FLR:  rd_mux = p0_floor;
			VTM_IDX_P1_PEAK: rd_mux = p1_peak;
			VTM_IDX_P1_FLR:  rd_mux = p1_floor;
			default:         map_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= (map_hit && addr_ok && !pwrite_i) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
			pslverr_q <= !(map_hit && addr_ok);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers; status is write one to clear, min and max readback are read only

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			gain_q   <= VTM_RST_GAIN;
			ctrl_a_q <= VTM_RST_CTRL_A;
			ctrl_b_q <= VTM_RST_CTRL_B;
			lim_p0_q <= VTM_RST_LIMITS;
			lim_p1_q <= VTM_RST_LIMITS;
			lim_t_q  <= VTM_RST_LIMITS;
			alm_en_q <= VTM_RST_ALM_EN;
		end else if (wr_en) begin
			case (idx)
				VTM_IDX_GAIN:   gain_q   <= pwdata_i[VTM_REG_W-1:0];
				VTM_IDX_CTRL_A: ctrl_a_q <= pwdata_i[VTM_REG_W-1:0];
				VTM_IDX_CTRL_B: ctrl_b_q <= pwdata_i[VTM_REG_W-1:0];
				VTM_IDX_LIM_P0: lim_p0_q <= pwdata_i[VTM_REG_W-1:0];
				VTM_IDX_LIM_P1: lim_p1_q <= pwdata_i[VTM_REG_W-1:0];
				VTM_IDX_LIM_T:  lim_t_q  <= pwdata_i[VTM_REG_W-1:0];
				VTM_IDX_ALM_EN: alm_en_q <= pwdata_i[VTM_REG_W-1:0];
				default: begin
				end
			endcase
		end
	end

	assign clr = (wr_en && idx == VTM_IDX_STATUS) ? pwdata_i[VTM_FLAG_N-1:0] : '0;

	// fields named once so the checkers and the checks read the same bits
	assign voltage_gain_divisor = gain_q[VTM_GAIN_MSB:0];
	assign pin0_upper_limit     = lim_p0_q[VTM_UP_MSB:VTM_UP_LSB];
	assign pin0_lower_limit     = lim_p0_q[VTM_LO_MSB:VTM_LO_LSB];
	assign pin1_upper_limit     = lim_p1_q[VTM_UP_MSB:VTM_UP_LSB];
	assign pin1_lower_limit     = lim_p1_q[VTM_LO_MSB:VTM_LO_LSB];
	assign temp_upper_limit     = lim_t_q[VTM_UP_MSB:VTM_UP_LSB];
	assign temp_lower_limit     = lim_t_q[VTM_LO_MSB:VTM_LO_LSB];
	assign meas_level           = meas_i.value[VTM_MEAS_W-1:VTM_LVL_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// sensor configuration

	// a zero divisor has no meaningful gain, so it reports zero rather than an unknown quotient from dividing by zero
	always_comb begin
		gain_calc = 8'h00;
		if (voltage_gain_divisor != '0) begin
			gain_calc = VTM_GAIN_NUM / {1'b0, voltage_gain_divisor};
		end
	end

	assign running = (ctrl_a_q[VTM_RUN_MSB:VTM_RUN_LSB] == VTM_RUN_ON);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_q <= '0;
		end else begin
			cfg_q.run        <= running;
			cfg_q.pin0_sense <= ctrl_a_q[VTM_SEL_P0];
			cfg_q.pin1_sense <= ctrl_a_q[VTM_SEL_P1];
			cfg_q.gain_apply <= ctrl_b_q[VTM_GAIN_APPLY];
			cfg_q.gain       <= ctrl_b_q[VTM_GAIN_APPLY] ? gain_calc : VTM_GAIN_UNITY;
		end
	end

	assign cfg_o = cfg_q;

	////////////////////////////////////////////////////////////////////////////////
	// limit checks: each sample is compared with the limits standing in its cycle

	assign samp_p0 = meas_i.valid && running && ctrl_a_q[VTM_SEL_P0] && meas_i.chan == VTM_CH_PIN0;
	assign samp_p1 = meas_i.valid && running && ctrl_a_q[VTM_SEL_P1] && meas_i.chan == VTM_CH_PIN1;
	assign samp_t  = meas_i.valid && running && meas_i.chan == VTM_CH_TEMP;

	vtm_limit_chk u_chk_p0 (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.sample_i    (samp_p0),
		.value_i     (meas_i.value),
		.upper_i     (pin0_upper_limit),
		.lower_i     (pin0_lower_limit),
		.clr_over_i  (clr[VTM_ST_P0_OVER]),
		.clr_under_i (clr[VTM_ST_P0_UNDER]),
		.over_o      (flags[VTM_ST_P0_OVER]),
		.under_o     (flags[VTM_ST_P0_UNDER]),
		.peak_o      (p0_peak),
		.floor_o     (p0_floor)
	);

	vtm_limit_chk u_chk_p1 (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.sample_i    (samp_p1),
		.value_i     (meas_i.value),
		.upper_i     (pin1_upper_limit),
		.lower_i     (pin1_lower_limit),
		.clr_over_i  (clr[VTM_ST_P1_OVER]),
		.clr_under_i (clr[VTM_ST_P1_UNDER]),
		.over_o      (flags[VTM_ST_P1_OVER]),
		.under_o     (flags[VTM_ST_P1_UNDER]),
		.peak_o      (p1_peak),
		.floor_o     (p1_floor)
	);

	// temperature extremes are not exposed, so its trackers are left open
	vtm_limit_chk u_chk_t (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.sample_i    (samp_t),
		.value_i     (meas_i.value),
		.upper_i     (temp_upper_limit),
		.lower_i     (temp_lower_limit),
		.clr_over_i  (clr[VTM_ST_T_OVER]),
		.clr_under_i (clr[VTM_ST_T_UNDER]),
		.over_o      (flags[VTM_ST_T_OVER]),
		.under_o     (flags[VTM_ST_T_UNDER]),
		.peak_o      (),
		.floor_o     ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// alarm output

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= |(flags & alm_en_q[VTM_FLAG_N-1:0]);
		end
	end

	assign alarm_o = alarm_q;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	a_gain_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ctrl_b_q[VTM_GAIN_APPLY] && gain_q[VTM_GAIN_MSB:0] == 7'h20 |=> cfg_q.gain == 8'h04)
		else $error("gain field 0x20 did not give gain 4");

	a_gain_bypass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!ctrl_b_q[VTM_GAIN_APPLY] |=> cfg_q.gain == 8'h01 && !cfg_q.gain_apply)
		else $error("gain used while apply bit clear");

	a_run_field: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ctrl_a_q[VTM_RUN_MSB:VTM_RUN_LSB] == 2'h0 |=> !cfg_q.run)
		else $error("monitor runs while disabled");

	a_run_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		running |=> cfg_q.run)
		else $error("monitor stopped while enabled");

	a_route_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> cfg_q.pin0_sense == $past(ctrl_a_q[VTM_SEL_P0]) &&
			cfg_q.pin1_sense == $past(ctrl_a_q[VTM_SEL_P1]))
		else $error("pin routing does not follow select");

	a_p0_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!ctrl_a_q[VTM_SEL_P0] |=> !$rose(flags[VTM_ST_P0_OVER]) && !$rose(flags[VTM_ST_P0_UNDER]))
		else $error("pin0 flag rose while pin0 not routed");

	a_p0_over: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p0 && meas_level > pin0_upper_limit |=> flags[VTM_ST_P0_OVER])
		else $error("pin0 over flag not set");

	a_p0_under: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p0 && meas_level < pin0_lower_limit |=> flags[VTM_ST_P0_UNDER])
		else $error("pin0 under flag not set");

	a_p0_peak: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p0 |=> p0_peak >= $past(meas_i.value) && p0_floor <= $past(meas_i.value))
		else $error("pin0 extremes miss a reading");

	a_p0_floor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!samp_p0 |=> $stable(p0_floor))
		else $error("pin0 floor moved without a pin0 reading");

	a_p1_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p1 && meas_level > pin1_upper_limit |=> flags[VTM_ST_P1_OVER])
		else $error("pin1 over flag not set");

	a_p1_under: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p1 && meas_level < pin1_lower_limit |=> flags[VTM_ST_P1_UNDER])
		else $error("pin1 under flag not set");

	a_p1_peak: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p1 |=> p1_peak >= $past(meas_i.value))
		else $error("pin1 peak misses a reading");

	a_p1_floor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_p1 |=> p1_floor <= $past(meas_i.value))
		else $error("pin1 floor misses a reading");

	a_t_over: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_t && meas_level > temp_upper_limit |=> flags[VTM_ST_T_OVER])
		else $error("temp over flag not set");

	a_t_under: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		samp_t && meas_level < temp_lower_limit |=> flags[VTM_ST_T_UNDER])
		else $error("temp under flag not set");

	a_no_sense_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!running |=> $stable(flags) || (|$past(clr)))
		else $error("flag rose while monitor stopped");

	a_alarm_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(flags & alm_en_q[VTM_FLAG_N-1:0]) == '0 |=> !alarm_o)
		else $error("alarm raised by a masked flag");

	a_alarm_fire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(flags & alm_en_q[VTM_FLAG_N-1:0]) != '0 |=> alarm_o)
		else $error("enabled flag did not raise alarm");

	a_flag_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clr[VTM_ST_T_OVER] && !(samp_t && meas_level > temp_upper_limit) |=> !flags[VTM_ST_T_OVER])
		else $error("temp over flag not cleared by software");

	a_flag_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		flags[VTM_ST_T_OVER] && !clr[VTM_ST_T_OVER] |=> flags[VTM_ST_T_OVER] [*1])
		else $error("temp over flag lost without a clear");

endmodule // vtm_monitor

// ==== shared/vtm_pkg.sv ====
// vtm_pkg: register map, field layout, reset values and carrier types of the voltage and temperature monitor
// assumes an apb slave with 32-bit data; each register takes one word at byte address four times its index
package vtm_pkg;

	localparam int          VTM_ADDR_W      = 8;
	localparam int          VTM_REG_W       = 8;
	localparam int          VTM_MEAS_W      = 8;
	localparam int          VTM_LIM_W       = 3;

	// register indexes; byte address is index times four
	localparam logic [5:0]  VTM_IDX_GAIN    = 6'h15;
	localparam logic [5:0]  VTM_IDX_CTRL_A  = 6'h17;
	localparam logic [5:0]  VTM_IDX_CTRL_B  = 6'h18;
	localparam logic [5:0]  VTM_IDX_LIM_P0  = 6'h19;
	localparam logic [5:0]  VTM_IDX_LIM_P1  = 6'h1a;
	localparam logic [5:0]  VTM_IDX_LIM_T   = 6'h1b;
	localparam logic [5:0]  VTM_IDX_ALM_EN  = 6'h1d;
	localparam logic [5:0]  VTM_IDX_STATUS  = 6'h30;
	localparam logic [5:0]  VTM_IDX_P0_PEAK = 6'h31;
	localparam logic [5:0]  VTM_IDX_P0_FLR  = 6'h32;
	localparam logic [5:0]  VTM_IDX_P1_PEAK = 6'h33;
	localparam logic [5:0]  VTM_IDX_P1_FLR  = 6'h34;

	// reset values
	localparam logic [7:0]  VTM_RST_GAIN    = 8'h20;
	localparam logic [7:0]  VTM_RST_CTRL_A  = 8'h3c;
	localparam logic [7:0]  VTM_RST_CTRL_B  = 8'h80;
	localparam logic [7:0]  VTM_RST_LIMITS  = 8'h62;
	localparam logic [7:0]  VTM_RST_ALM_EN  = 8'h00;
	localparam logic [7:0]  VTM_RST_PEAK    = 8'h00;
	localparam logic [7:0]  VTM_RST_FLOOR   = 8'hff;

	// field positions
	localparam int          VTM_GAIN_MSB    = 6;
	localparam int          VTM_GAIN_APPLY  = 7;
	localparam int          VTM_RUN_MSB     = 3;
	localparam int          VTM_RUN_LSB     = 2;
	localparam int          VTM_SEL_P0      = 0;
	localparam int          VTM_SEL_P1      = 1;
	localparam int          VTM_UP_MSB      = 6;
	localparam int          VTM_UP_LSB      = 4;
	localparam int          VTM_LO_MSB      = 2;
	localparam int          VTM_LO_LSB      = 0;
	localparam int          VTM_FLAG_N      = 6;
	localparam int          VTM_LVL_LSB     = 5;

	// status and alarm-enable bit order
	localparam int          VTM_ST_P0_UNDER = 0;
	localparam int          VTM_ST_P0_OVER  = 1;
	localparam int          VTM_ST_P1_UNDER = 2;
	localparam int          VTM_ST_P1_OVER  = 3;
	localparam int          VTM_ST_T_UNDER  = 4;
	localparam int          VTM_ST_T_OVER   = 5;

	localparam logic [1:0]  VTM_RUN_ON      = 2'h3;
	localparam logic [7:0]  VTM_GAIN_NUM    = 8'h80;
	localparam logic [7:0]  VTM_GAIN_UNITY  = 8'h01;

	typedef enum logic [1:0] {
		VTM_CH_PIN0 = 2'b00,
		VTM_CH_PIN1 = 2'b01,
		VTM_CH_TEMP = 2'b10,
		VTM_CH_NONE = 2'b11
	} vtm_chan_t;

	typedef struct packed {
		logic                   valid;
		vtm_chan_t              chan;
		logic [VTM_MEAS_W-1:0]  value;
	} vtm_meas_t;

	typedef struct packed {
		logic                   run;
		logic                   pin0_sense;
		logic                   pin1_sense;
		logic                   gain_apply;
		logic [7:0]             gain;
	} vtm_cfg_t;

endpackage

// ==== core/vtm_limit_chk.sv ====
// vtm_limit_chk: one channel's limit compare with sticky flags and peak and floor tracking
// assumes sample_i is already qualified by enable and routing in the parent
`timescale 1ns/1ps
module vtm_limit_chk
	import vtm_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  sample_i,
	input  wire logic [VTM_MEAS_W-1:0] value_i,
	input  wire logic [VTM_LIM_W-1:0]  upper_i,
	input  wire logic [VTM_LIM_W-1:0]  lower_i,
	input  wire logic                  clr_over_i,
	input  wire logic                  clr_under_i,
	output logic                       over_o,
	output logic                       under_o,
	output logic [VTM_MEAS_W-1:0]      peak_o,
	output logic [VTM_MEAS_W-1:0]      floor_o
);

	logic [VTM_LIM_W-1:0]  level;
	logic                  over_hit;
	logic                  under_hit;
	logic                  over_q;
	logic                  under_q;
	logic [VTM_MEAS_W-1:0] peak_q;
	logic [VTM_MEAS_W-1:0] floor_q;

	// limits are coarse, so only the top bits of the reading take part
	assign level     = value_i[VTM_MEAS_W-1:VTM_LVL_LSB];
	assign over_hit  = sample_i && (level > upper_i);
	assign under_hit = sample_i && (level < lower_i);

	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			over_q  <= 1'b0;
			under_q <= 1'b0;
		end else begin
			over_q  <= over_hit  | (over_q  & ~clr_over_i);
			under_q <= under_hit | (under_q & ~clr_under_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			peak_q  <= VTM_RST_PEAK;
			floor_q <= VTM_RST_FLOOR;
		end else if (sample_i) begin
			if (value_i > peak_q) begin
				peak_q <= value_i;
			end
			if (value_i < floor_q) begin
				floor_q <= value_i;
			end
		end
	end

	assign over_o  = over_q;
	assign under_o = under_q;
	assign peak_o  = peak_q;
	assign floor_o = floor_q;

endmodule // vtm_limit_chk

// ==== bench/vtm_fe_model.sv ====
// vtm_fe_model: behavioural sensing front end, hands the monitor one measurement per call
// assumes the monitor samples meas_o on the rising edge of clk_i
`timescale 1ns/1ps
module vtm_fe_model
	import vtm_pkg::*;
(
	input  wire logic clk_i,
	output vtm_meas_t meas_o
);
	initial begin
		meas_o = '{valid: 1'b0, chan: VTM_CH_NONE, value: 8'h5a};
	end
	// one valid cycle per call; the value then flips so a stale reading never looks held
	task automatic sample(input vtm_chan_t ch, input logic [7:0] v);
		@(posedge clk_i);
		meas_o <= '{valid: 1'b1, chan: ch, value: v};
		@(posedge clk_i);
		meas_o <= '{valid: 1'b0, chan: VTM_CH_NONE, value: ~v};
	endtask
endmodule // vtm_fe_model

// ==== bench/testbench.sv ====
// testbench: self-checking bench of the monitor, an apb master and one task per scenario
// assumes vtm_fe_model as the sensing front end; every wait is bounded by the cycle ceiling
`timescale 1ns/1ps
module testbench
	import vtm_pkg::*;
;
	logic        clk_i;
	logic        sys_rst_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i;
	logic [3:0]  pstrb_i;
	logic        pready_o;
	logic [31:0] prdata_o;
	logic        pslverr_o;
	vtm_meas_t   meas_i;
	vtm_cfg_t    cfg_o;
	logic        alarm_o;
	int          n_fail;
	int          n_tests;
	int          cycles;

	vtm_monitor u_vtm_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o), .meas_i(meas_i), .cfg_o(cfg_o), .alarm_o(alarm_o));
	vtm_fe_model u_vtm_fe_model (.clk_i(clk_i), .meas_o(meas_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held from setup until pready is seen high; data and error taken at that edge only
	task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, {24'h0, d}, r, e);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0, r, e);
		chk(r, {24'h0, exp});
		chk({31'h0, e}, 32'h0);
	endtask

	// cfg_o follows a register change one cycle later
	task automatic chk_cfg(input logic [11:0] exp);
		@(posedge clk_i);
		#1;
		chk({20'h0, cfg_o}, {20'h0, exp});
	endtask

	task automatic chk_alarm(input logic exp);
		@(posedge clk_i);
		@(posedge clk_i);
		#1;
		chk({31'h0, alarm_o}, {31'h0, exp});
	endtask

	task automatic smp(input vtm_chan_t c, input logic [7:0] v);
		u_vtm_fe_model.sample(c, v);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [5:0]  ri [12] = '{VTM_IDX_GAIN, VTM_IDX_CTRL_A, VTM_IDX_CTRL_B, VTM_IDX_LIM_P0, VTM_IDX_LIM_P1,
			VTM_IDX_LIM_T, VTM_IDX_ALM_EN, VTM_IDX_STATUS, VTM_IDX_P0_PEAK, VTM_IDX_P0_FLR, VTM_IDX_P1_PEAK,
			VTM_IDX_P1_FLR};
		logic [7:0]  rv [12] = '{8'h20, 8'h3c, 8'h80, 8'h62, 8'h62, 8'h62, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
			8'hff};
		logic [31:0] r;
		logic        e;
		chk_cfg({4'b1001, 8'h04});
		for (int i = 0; i < 12; i++) begin
			rd_chk(ri[i], rv[i]);
		end
		apb(1'b0, 6'h3f, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
	endtask

	task automatic t_gain();
		wr(VTM_IDX_GAIN, 8'h40);
		chk_cfg({4'b1001, 8'h02});
		wr(VTM_IDX_GAIN, 8'h90);
		chk_cfg({4'b1001, 8'h08});
		@(posedge clk_i);
		pstrb_i <= 4'h0;
		wr(VTM_IDX_GAIN, 8'h40);
		pstrb_i <= 4'h1;
		rd_chk(VTM_IDX_GAIN, 8'h90);
		wr(VTM_IDX_CTRL_B, 8'h00);
		chk_cfg({4'b1000, 8'h01});
		wr(VTM_IDX_CTRL_B, 8'h80);
		wr(VTM_IDX_GAIN, 8'h20);
	endtask

	// limits 6 and 2 first, then upper lowered to 5 between samples
	task automatic t_limits(input vtm_chan_t ch, input logic [5:0] li, input logic [5:0] pk, input int bu);
		wr(VTM_IDX_STATUS, 8'h3f);
		smp(ch, 8'h40);
		smp(ch, 8'hc0);
		smp(ch, 8'h3f);
		rd_chk(VTM_IDX_STATUS, 8'h01 << bu);
		wr(li, 8'h52);
		smp(ch, 8'h80);
		rd_chk(VTM_IDX_STATUS, 8'h01 << bu);
		smp(ch, 8'hc0);
		rd_chk(VTM_IDX_STATUS, 8'h03 << bu);
		if (ch != VTM_CH_TEMP) begin
			rd_chk(pk, 8'hc0);
			rd_chk(pk + 6'h01, 8'h3f);
		end
		wr(VTM_IDX_STATUS, 8'h01 << bu);
		rd_chk(VTM_IDX_STATUS, 8'h02 << bu);
		wr(li, VTM_RST_LIMITS);
	endtask

	task automatic t_route();
		for (int s = 0; s < 4; s++) begin
			wr(VTM_IDX_CTRL_A, {6'h0f, s[1:0]});
			wr(VTM_IDX_STATUS, 8'h3f);
			smp(VTM_CH_PIN0, 8'he0);
			smp(VTM_CH_PIN1, 8'h00);
			rd_chk(VTM_IDX_STATUS, {5'h00, s[1], s[0], 1'b0});
			chk({20'h0, cfg_o}, {20'h0, 1'b1, s[0], s[1], 1'b1, 8'h04});
		end
	endtask

	task automatic t_stop();
		for (int m = 0; m < 3; m++) begin
			wr(VTM_IDX_CTRL_A, {4'h3, m[1:0], 2'b11});
			wr(VTM_IDX_STATUS, 8'h3f);
			smp(VTM_CH_TEMP, 8'he0);
			smp(VTM_CH_PIN0, 8'h00);
			rd_chk(VTM_IDX_STATUS, 8'h00);
			chk({31'h0, cfg_o.run}, 32'h0);
		end
		wr(VTM_IDX_CTRL_A, 8'h3f);
	endtask

	task automatic t_alarm();
		wr(VTM_IDX_STATUS, 8'h3f);
		smp(VTM_CH_PIN0, 8'he0);
		smp(VTM_CH_PIN0, 8'h00);
		smp(VTM_CH_PIN1, 8'he0);
		smp(VTM_CH_PIN1, 8'h00);
		smp(VTM_CH_TEMP, 8'he0);
		smp(VTM_CH_TEMP, 8'h00);
		rd_chk(VTM_IDX_STATUS, 8'h3f);
		chk_alarm(1'b0);
		for (int i = 0; i < 6; i++) begin
			wr(VTM_IDX_ALM_EN, 8'h01 << i);
			chk_alarm(1'b1);
			wr(VTM_IDX_STATUS, 8'h01 << i);
			chk_alarm(1'b0);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// the whole run needs under 400 cycles; the ceiling leaves ample margin
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		n_fail = 0;
		n_tests = 0;
		cycles = 0;
		sys_rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		pstrb_i = 4'h1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_gain();
		wr(VTM_IDX_CTRL_A, 8'h3f);
		t_limits(VTM_CH_PIN0, VTM_IDX_LIM_P0, VTM_IDX_P0_PEAK, VTM_ST_P0_UNDER);
		t_limits(VTM_CH_PIN1, VTM_IDX_LIM_P1, VTM_IDX_P1_PEAK, VTM_ST_P1_UNDER);
		t_limits(VTM_CH_TEMP, VTM_IDX_LIM_T, VTM_IDX_P1_PEAK, VTM_ST_T_UNDER);
		t_route();
		t_stop();
		t_alarm();
		summarize();
	end
endmodule // testbench
